/* File: meter_regs_consts.vh */
// Constants for the upper page-zero register bank of the meter core.
// Assumes inclusion by bare name from the register bank modules.
`ifndef METER_REGS_CONSTS_VH
`define METER_REGS_CONSTS_VH
// Register addresses (5-bit word index within a page)
`define ADDR_DIE_TEMPERATURE 5'h1B
`define ADDR_CONTROL_SETTINGS 5'h1C
`define ADDR_ACTIVE_PULSE 5'h1D
`define ADDR_APPARENT_PULSE 5'h1E
`define ADDR_REACTIVE_PULSE 5'h1F
`define ADDR_PAGE_SELECT 5'h1F
// Reset values
`define CONTROL_RESET 24'h000000
`define PAGE_RESET 7'h00
`define DATA_RESET 24'h000000
// Page holding these registers
`define PAGE_ZERO 7'h00
// Control field positions
`define CTL_PHASE_MSB 23
`define CTL_PHASE_LSB 16
`define CTL_GAIN2_BIT 12
`define CTL_STOP_BIT 8
`define CTL_GAIN1_BIT 5
`define CTL_OPEN_DRAIN_BIT 4
`define CTL_CLK_OFF_BIT 2
`define CTL_OSC_OFF_BIT 1
// Mask of implemented control bits
`define CTL_WRITE_MASK 24'hFF1136
`endif

/* File: result_holder.v */
// Holds one 24-bit measurement result, loaded on an update strobe.
// Assumes the producer presents a stable value with its strobe.
`timescale 1ns/1ps
`include "meter_regs_consts.vh"
module result_holder #(
  parameter WIDTH = 24
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Producer side
  input wire upd,
  input wire [WIDTH-1:0] din,
  // Held value
  output reg [WIDTH-1:0] dout_q
);
  // Capture a new result on each update strobe
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dout_q <= {WIDTH{1'b0}};
    else if (upd)
      dout_q <= din;
  end
endmodule // result_holder

/* File: meter_upper_page_registers.v */
// Upper page-zero registers: temperature, control, pulse accumulators
// and page select. Assumes a serial front end that presents decoded
// word reads and writes synchronous to clk, and a measurement core that
// strobes new results in after each conversion or computation cycle.
`timescale 1ns/1ps
`include "meter_regs_consts.vh"
// Function
// - Temperature at address 27, signed 8.16
// - Temperature refreshed during continuous conversions
// - Control bits 23:16 give channel-2 phase delay
// - Bits 5 and 12 pick gain 10/50
// - Control bit 8 stops auto-boot load
// - Control bit 4 makes interrupt pin open drain
// - Control bit 2 disables processor clock output
// - Control bit 1 switches crystal oscillator off
// - Active energy at address 29 drives pulses
// - Apparent power at 30, updated per cycle
// - Read of 31 returns reactive accumulator
// - Write of 31 loads seven-bit page, reset zero
module meter_upper_page_registers #(
  parameter DW = 24,
  parameter AW = 5,
  parameter PW = 7
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register access from serial front end
  input wire reg_wr,
  input wire reg_rd,
  input wire [AW-1:0] reg_addr,
  input wire [DW-1:0] reg_wdata,
  output reg [DW-1:0] reg_rdata_q,
  output reg reg_rvalid_q,
  output reg reg_hit_q,
  // Results from the measurement core
  input wire conv_running,
  input wire temp_upd,
  input wire [DW-1:0] temp_in,
  input wire cycle_upd,
  input wire [DW-1:0] active_in,
  input wire [DW-1:0] apparent_in,
  input wire [DW-1:0] reactive_in,
  // Values to the pulse generator
  output wire [DW-1:0] active_energy_pulse_accum,
  output wire [DW-1:0] apparent_energy_pulse_accum,
  output wire [DW-1:0] reactive_energy_pulse_accum,
  // Control outputs
  output wire [7:0] phase_delay_ch2,
  output wire first_current_gain_sel,
  output wire second_current_gain_sel,
  output wire boot_stop,
  output wire irq_open_drain_sel,
  output wire proc_clock_out_off,
  output wire crystal_osc_off,
  // Page selection
  output reg [PW-1:0] page_q,
  // Interrupt pin driver
  input wire irq_req,
  output wire irq_pin_o,
  output wire irq_pin_oe
);
  // Control register and its next value
  reg [DW-1:0] ctl_q;
  reg [DW-1:0] ctl_d;
  // Held results
  wire [DW-1:0] temp_q;
  wire [DW-1:0] active_q;
  wire [DW-1:0] apparent_q;
  wire [DW-1:0] reactive_q;
  // Write strobes
  wire wr_ctl;
  wire wr_page;
  // Read data next value
  reg [DW-1:0] rdata_d;
  reg hit_d;

  // Address match restricted to page zero
  function hit;
    input [AW-1:0] a;
    input [AW-1:0] target;
    input [PW-1:0] pg;
    begin
      hit = (a == target) && (pg == `PAGE_ZERO);
    end
  endfunction

  // Temperature refreshed only while conversions run
  result_holder #(.WIDTH(DW)) u_temp (
    .clk(clk),
    .nrst(nrst),
    .upd(temp_upd & conv_running),
    .din(temp_in),
    .dout_q(temp_q)
  );

  // Pulse accumulators refreshed once per computation cycle
  // Active energy accumulator
  result_holder #(.WIDTH(DW)) u_active (
    .clk(clk),
    .nrst(nrst),
    .upd(cycle_upd),
    .din(active_in),
    .dout_q(active_q)
  );

  // Apparent power accumulator
  result_holder #(.WIDTH(DW)) u_apparent (
    .clk(clk),
    .nrst(nrst),
    .upd(cycle_upd),
    .din(apparent_in),
    .dout_q(apparent_q)
  );

  // Reactive power accumulator
  result_holder #(.WIDTH(DW)) u_reactive (
    .clk(clk),
    .nrst(nrst),
    .upd(cycle_upd),
    .din(reactive_in),
    .dout_q(reactive_q)
  );

  // Write strobes; page register is write-only and reachable from any
  // page so the host can always return to page zero
  assign wr_ctl = reg_wr && hit(reg_addr, `ADDR_CONTROL_SETTINGS, page_q);
  assign wr_page = reg_wr && (reg_addr == `ADDR_PAGE_SELECT);

  // Control next value, unassigned bits forced to zero
  always @*
  begin
    ctl_d = ctl_q;
    // Writes on other pages leave control untouched
    if (wr_ctl)
      ctl_d = reg_wdata & `CTL_WRITE_MASK;
  end

  // Control and page registers
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Power-up defaults
      ctl_q <= `CONTROL_RESET;
      page_q <= `PAGE_RESET;
    end
    else
    begin
      ctl_q <= ctl_d;
      // Page loads from any page so the host can always return
      if (wr_page)
        page_q <= reg_wdata[PW-1:0];
    end
  end

  // Read multiplexer
  always @*
  begin
    rdata_d = `DATA_RESET;
    hit_d = 1'b1;
    // Other pages map nothing in this bank
    if (page_q != `PAGE_ZERO)
      hit_d = 1'b0;
    else
    begin
      // Page zero word decode
      case (reg_addr)
        `ADDR_DIE_TEMPERATURE: rdata_d = temp_q;
        `ADDR_CONTROL_SETTINGS: rdata_d = ctl_q;
        `ADDR_ACTIVE_PULSE: rdata_d = active_q;
        `ADDR_APPARENT_PULSE: rdata_d = apparent_q;
        `ADDR_REACTIVE_PULSE: rdata_d = reactive_q;
        default: hit_d = 1'b0;
      endcase
    end
  end

  // Registered read answer, one cycle after the read strobe
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata_q <= `DATA_RESET;
      reg_rvalid_q <= 1'b0;
      reg_hit_q <= 1'b0;
    end
    else
    begin
      // Valid follows every read strobe by one cycle
      reg_rvalid_q <= reg_rd;
      // Data and hit hold until the next read
      if (reg_rd)
      begin
        reg_rdata_q <= rdata_d;
        reg_hit_q <= hit_d;
      end
    end
  end

  // Accumulators to pulse generator
  assign active_energy_pulse_accum = active_q;
  assign apparent_energy_pulse_accum = apparent_q;
  assign reactive_energy_pulse_accum = reactive_q;

  // Control fields
  assign phase_delay_ch2 = ctl_q[`CTL_PHASE_MSB:`CTL_PHASE_LSB];
  // Gains: zero selects 10, one selects 50
  assign first_current_gain_sel = ctl_q[`CTL_GAIN1_BIT];
  assign second_current_gain_sel = ctl_q[`CTL_GAIN2_BIT];
  assign boot_stop = ctl_q[`CTL_STOP_BIT];
  assign irq_open_drain_sel = ctl_q[`CTL_OPEN_DRAIN_BIT];
  // Power-saving switches for clock output and oscillator
  assign proc_clock_out_off = ctl_q[`CTL_CLK_OFF_BIT];
  assign crystal_osc_off = ctl_q[`CTL_OSC_OFF_BIT];

  // Interrupt pin: push-pull drives both levels, open drain only low
  // In open drain mode the pin floats while an interrupt is pending,
  // so an external pull-up sets that level
  assign irq_pin_o = irq_open_drain_sel ? 1'b0 : irq_req;
  assign irq_pin_oe = irq_open_drain_sel ? ~irq_req : 1'b1;
endmodule // meter_upper_page_registers

/* File: meter_upper_page_registers_monitor.sv */
// Checker for the upper register bank, bound to its ports.
// Assumes one clock domain and active-low nrst.
`timescale 1ns/1ps
module regs_monitor (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [4:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_rvalid_q,
  input wire [6:0] page_q,
  // Control outputs and pin
  input wire [7:0] phase_delay_ch2,
  input wire boot_stop,
  input wire irq_open_drain_sel,
  input wire irq_req,
  input wire irq_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Control write that lands on page zero
  wire ctl_wr = reg_wr && reg_addr == 5'h1C && page_q == 7'h00;
  property p_rv; reg_rd |=> reg_rvalid_q; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_norv; !reg_rd |=> !reg_rvalid_q; endproperty
  a_norv: assert property (p_norv) else $error("stray read valid");
  property p_pg; reg_wr && reg_addr == 5'h1F |=>
    page_q == $past(reg_wdata[6:0]); endproperty
  a_pg: assert property (p_pg) else $error("page not loaded");
  property p_ph; ctl_wr |=> phase_delay_ch2 == $past(reg_wdata[23:16]);
  endproperty
  a_ph: assert property (p_ph) else $error("phase not loaded");
  property p_hold; !ctl_wr |=> $stable(phase_delay_ch2); endproperty
  a_hold: assert property (p_hold) else $error("phase moved");
  property p_st; ctl_wr |=> boot_stop == $past(reg_wdata[8]); endproperty
  a_st: assert property (p_st) else $error("stop not loaded");
  property p_od; irq_open_drain_sel |-> irq_pin_oe == !irq_req; endproperty
  a_od: assert property (p_od) else $error("open drain wrong");
  property p_drv; !irq_open_drain_sel |-> irq_pin_oe; endproperty
  a_drv: assert property (p_drv) else $error("pin not driven");
endmodule // regs_monitor
bind meter_upper_page_registers regs_monitor mon_u (.*);

/* File: host_model.sv */
// Host side of the register port: word writes and reads.
// Assumes strobes are taken on the rising edge of clk.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire clk,
  // Requests
  output reg reg_wr,
  output reg reg_rd,
  output reg [4:0] reg_addr,
  output reg [23:0] reg_wdata,
  // Answers
  input wire [23:0] reg_rdata_q,
  input wire reg_hit_q,
  input wire reg_rvalid_q
);
  // Idle port at time zero
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 31'h00000000;
  // Word write; the top address changes page
  task wr(input [4:0] a, input [23:0] d);
    begin
      @(posedge clk);
      #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1 reg_wr = 1'b0;
      // Released data does not keep its value
      reg_wdata = ~d;
    end
  endtask
  // Word read; answer taken the cycle after the request
  task rd(input [4:0] a, output [23:0] d, output [1:0] f);
    begin
      @(posedge clk);
      #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      d = reg_rdata_q;
      f = {reg_hit_q, reg_rvalid_q};
    end
  endtask
endmodule // host_model

/* File: meter_upper_page_registers_tb.sv */
// Self-checking bench for the upper register bank.
// Assumes host_model drives the register port.
`timescale 1ns/1ps
module meter_upper_page_registers_tb;
  // Clock, reset and measurement core side
  logic clk = 1'b0, nrst = 1'b0, conv_running = 1'b0, irq_req = 1'b0;
  logic temp_upd = 1'b0, cycle_upd = 1'b0;
  logic [23:0] temp_in = 24'h000000, active_in = 24'h000000;
  logic [23:0] apparent_in = 24'h000000, reactive_in = 24'h000000;
  // Register port and design outputs
  wire reg_wr, reg_rd, reg_rvalid_q, reg_hit_q, boot_stop, irq_pin_o;
  wire first_current_gain_sel, second_current_gain_sel, irq_pin_oe;
  wire irq_open_drain_sel, proc_clock_out_off, crystal_osc_off;
  wire [4:0] reg_addr;
  wire [6:0] page_q;
  wire [7:0] phase_delay_ch2;
  wire [23:0] reg_wdata, reg_rdata_q, active_energy_pulse_accum;
  wire [23:0] apparent_energy_pulse_accum, reactive_energy_pulse_accum;
  // Read results, control value and tally
  logic [23:0] d, v;
  logic [1:0] f;
  int miscompares = 0, total_checks = 0;
  meter_upper_page_registers dut_u (.*);
  host_model host_u (.*);
  always #20 clk = ~clk;
  // Compare one value
  task chk(input [23:0] got, input [23:0] exp);
    begin
      total_checks++;
      if (got !== exp)
      begin
        miscompares++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Read and compare data, hit and valid
  task rc(input [4:0] a, input [23:0] exp, input h);
    begin
      host_u.rd(a, d, f);
      chk(d, exp);
      chk({22'h000000, f}, {22'h000000, h, 1'b1});
    end
  endtask
  // One-cycle strobe: temperature or computation cycle
  task strobe(input t);
    begin
      @(posedge clk);
      #1 temp_upd = t;
      cycle_upd = !t;
      @(posedge clk);
      #1 temp_upd = 1'b0;
      cycle_upd = 1'b0;
    end
  endtask
  // Counts and verdict
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    rc(5'h1C, 24'h000000, 1'b1);
    rc(5'h00, 24'h000000, 1'b0);
    irq_req = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 24'h5A1024 : 24'hFFFFFF;
      host_u.wr(5'h1C, v);
      rc(5'h1C, v & 24'hFF1136, 1'b1);
      chk({10'h000, phase_delay_ch2, second_current_gain_sel, boot_stop,
        first_current_gain_sel, irq_open_drain_sel, proc_clock_out_off,
        crystal_osc_off}, {10'h000, v[23:16], v[12], v[8], v[5], v[4],
        v[2], v[1]});
      chk({22'h000000, irq_pin_o, irq_pin_oe},
        v[4] ? 24'h000000 : 24'h000003);
    end
    $display("control test done");
    temp_in = 24'h801234;
    strobe(1'b1);
    rc(5'h1B, 24'h000000, 1'b1);
    conv_running = 1'b1;
    strobe(1'b1);
    host_u.wr(5'h1B, 24'h000000);
    rc(5'h1B, 24'h801234, 1'b1);
    active_in = 24'h812345;
    apparent_in = 24'h7FFFFF;
    reactive_in = 24'hC00001;
    strobe(1'b0);
    rc(5'h1D, 24'h812345, 1'b1);
    rc(5'h1E, 24'h7FFFFF, 1'b1);
    rc(5'h1F, 24'hC00001, 1'b1);
    chk(reactive_energy_pulse_accum, 24'hC00001);
    chk(active_energy_pulse_accum, 24'h812345);
    chk(apparent_energy_pulse_accum, 24'h7FFFFF);
    $display("result test done");
    host_u.wr(5'h1F, 24'hFFFF85);
    chk({17'h00000, page_q}, 24'h000005);
    host_u.wr(5'h1C, 24'h000000);
    rc(5'h1C, 24'h000000, 1'b0);
    host_u.wr(5'h1F, 24'h000000);
    rc(5'h1C, 24'h5A1024, 1'b1);
    $display("page test done");
    conclude;
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #20000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude;
  end
endmodule // meter_upper_page_registers_tb
